//--- common/tpb_pkg.sv
// Register map, field layout, reset values and timing constants of the pin B timer channel.
package tpb_pkg;
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_MODE = 8'h04;
  localparam logic [7:0] OFF_LIVE_COUNT = 8'h10;
  localparam logic [7:0] OFF_CAPTURE_COMPARE_A = 8'h14;
  localparam logic [7:0] OFF_CAPTURE_COMPARE_B = 8'h18;
  localparam logic [7:0] OFF_PERIOD_COMPARE_C = 8'h1C;

  // Control register fields.
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_SW_TRIGGER_BIT = 2;
  localparam int CTRL_PIN_B_MIRROR_BIT = 16;

  // Mode register fields.
  localparam int MODE_EVENT_EDGE_LSB = 8;
  localparam int MODE_EVENT_SOURCE_LSB = 10;
  localparam int MODE_WAVE_BIT = 15;
  localparam int MODE_CMP_B_ACTION_LSB = 24;
  localparam int MODE_CMP_C_ACTION_LSB = 26;
  localparam int MODE_EVENT_ACTION_LSB = 28;
  localparam int MODE_SW_TRIGGER_ACTION_LSB = 30;

  localparam logic [31:0] MODE_RESET = 32'h0000_0000;
  localparam logic [15:0] VALUE_RESET = 16'h0000;
  localparam int COUNT_WIDTH = 16;

  // Pin action encodings.
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_SET = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;

  // Event source and edge encodings.
  localparam logic [1:0] SRC_PIN_B = 2'h0;
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISING = 2'h1;
  localparam logic [1:0] EDGE_FALLING = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // Counter clock: the channel clock divided by this many cycles.
  localparam int COUNT_PRESCALE = 2;
endpackage

//--- design/tpb_channel.sv
// Timer channel: counter, compare registers A/B/C, pin B waveform logic and APB slave.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/10ps
module tpb_channel #(
  parameter int PRESCALE = tpb_pkg::COUNT_PRESCALE
) (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic [2:0] I_XC,
  input wire logic I_PIN_B,
  output logic O_PIN_B,
  output logic O_PIN_B_OE
);
  localparam int CW = tpb_pkg::COUNT_WIDTH;

  logic enable_q;
  logic [31:0] mode_q;
  logic [CW-1:0] count_q;
  logic [CW-1:0] reg_a_q;
  logic [CW-1:0] reg_b_q;
  logic [CW-1:0] reg_c_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic pin_q;
  logic oe_q;
  logic sw_trig_q;
  logic [31:0] pre_q;
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic ev_prev_q;

  logic access;
  logic wr_en;
  logic mapped;
  logic wave;
  logic [1:0] ev_src;
  logic [1:0] ev_edge;
  logic [1:0] act_b;
  logic [1:0] act_c;
  logic [1:0] act_ev;
  logic [1:0] act_sw;
  logic tick;
  logic hit_b;
  logic hit_c;
  logic ev_level;
  logic ev_hit;
  logic [1:0] act_sel;
  logic act_valid;
  logic [31:0] rd_data;

  assign wave = mode_q[tpb_pkg::MODE_WAVE_BIT];
  assign ev_src = mode_q[tpb_pkg::MODE_EVENT_SOURCE_LSB +: 2];
  assign ev_edge = mode_q[tpb_pkg::MODE_EVENT_EDGE_LSB +: 2];
  assign act_b = mode_q[tpb_pkg::MODE_CMP_B_ACTION_LSB +: 2];
  assign act_c = mode_q[tpb_pkg::MODE_CMP_C_ACTION_LSB +: 2];
  assign act_ev = mode_q[tpb_pkg::MODE_EVENT_ACTION_LSB +: 2];
  assign act_sw = mode_q[tpb_pkg::MODE_SW_TRIGGER_ACTION_LSB +: 2];

  // The answer comes one cycle into the access phase; the write lands on the next edge, which ends the transfer.
  assign access = I_PSEL && I_PENABLE;
  assign wr_en = access && pready_q && I_PWRITE;

  // APB handshake and registered read data.
  always_comb begin
    mapped = 1'b1;
    rd_data = 32'h0000_0000;
    case (I_PADDR)
      tpb_pkg::OFF_CONTROL: begin
        rd_data[tpb_pkg::CTRL_ENABLE_BIT] = enable_q;
        rd_data[tpb_pkg::CTRL_PIN_B_MIRROR_BIT] = oe_q ? pin_q : sync2_q[0];
      end
      tpb_pkg::OFF_MODE: rd_data = mode_q;
      tpb_pkg::OFF_LIVE_COUNT: rd_data = {16'h0000, count_q};
      tpb_pkg::OFF_CAPTURE_COMPARE_A: rd_data = {16'h0000, reg_a_q};
      tpb_pkg::OFF_CAPTURE_COMPARE_B: rd_data = {16'h0000, reg_b_q};
      tpb_pkg::OFF_PERIOD_COMPARE_C: rd_data = {16'h0000, reg_c_q};
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else if (access && !pready_q) begin
      pready_q <= 1'b1;
      pslverr_q <= !mapped;
      prdata_q <= I_PWRITE ? 32'h0000_0000 : rd_data;
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  // Software-visible configuration.
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      enable_q <= 1'b0;
      mode_q <= tpb_pkg::MODE_RESET;
      sw_trig_q <= 1'b0;
    end else begin
      sw_trig_q <= wr_en && I_PADDR == tpb_pkg::OFF_CONTROL &&
                   I_PWDATA[tpb_pkg::CTRL_SW_TRIGGER_BIT];
      if (wr_en && I_PADDR == tpb_pkg::OFF_CONTROL) begin
        enable_q <= I_PWDATA[tpb_pkg::CTRL_ENABLE_BIT];
      end
      if (wr_en && I_PADDR == tpb_pkg::OFF_MODE) begin
        mode_q <= I_PWDATA;
      end
    end
  end

  // Compare registers; A and B refuse writes in capture mode without any error.
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      reg_a_q <= tpb_pkg::VALUE_RESET;
      reg_b_q <= tpb_pkg::VALUE_RESET;
      reg_c_q <= tpb_pkg::VALUE_RESET;
    end else if (wr_en) begin
      if (I_PADDR == tpb_pkg::OFF_CAPTURE_COMPARE_A && wave) begin
        reg_a_q <= I_PWDATA[CW-1:0];
      end
      if (I_PADDR == tpb_pkg::OFF_CAPTURE_COMPARE_B && wave) begin
        reg_b_q <= I_PWDATA[CW-1:0];
      end
      if (I_PADDR == tpb_pkg::OFF_PERIOD_COMPARE_C) begin
        reg_c_q <= I_PWDATA[CW-1:0];
      end
    end
  end

  // Counter clock enable from a divider, then the 16-bit wrapping counter.
  always_ff @(posedge I_CLK) begin
    if (I_RST || !enable_q) begin
      pre_q <= 32'h0000_0000;
    end else if (pre_q == 32'(PRESCALE - 1)) begin
      pre_q <= 32'h0000_0000;
    end else begin
      pre_q <= pre_q + 32'h0000_0001;
    end
  end
  assign tick = enable_q && pre_q == 32'(PRESCALE - 1);

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      count_q <= tpb_pkg::VALUE_RESET;
    end else if (tick) begin
      count_q <= count_q + 16'h0001;
    end
  end

  // A match is seen once, on the tick at which the counter holds the compare value.
  assign hit_b = tick && count_q == reg_b_q;
  assign hit_c = tick && count_q == reg_c_q;

  // Pin B and the three external clock inputs each pass two flip-flops.
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
      ev_prev_q <= 1'b0;
    end else begin
      sync1_q <= {I_XC, I_PIN_B};
      sync2_q <= sync1_q;
      ev_prev_q <= ev_level;
    end
  end
  assign ev_level = sync2_q[ev_src];

  always_comb begin
    case (ev_edge)
      tpb_pkg::EDGE_RISING: ev_hit = ev_level && !ev_prev_q;
      tpb_pkg::EDGE_FALLING: ev_hit = !ev_level && ev_prev_q;
      tpb_pkg::EDGE_BOTH: ev_hit = ev_level != ev_prev_q;
      default: ev_hit = 1'b0;
    endcase
  end

  // Highest-priority source decides; a lower one in the same cycle is dropped.
  always_comb begin
    act_valid = 1'b1;
    if (sw_trig_q) begin
      act_sel = act_sw;
    end else if (ev_hit) begin
      act_sel = act_ev;
    end else if (hit_c) begin
      act_sel = act_c;
    end else if (hit_b) begin
      act_sel = act_b;
    end else begin
      act_sel = tpb_pkg::ACT_NONE;
      act_valid = 1'b0;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      pin_q <= 1'b0;
    end else if (wave && act_valid) begin
      case (act_sel)
        tpb_pkg::ACT_SET: pin_q <= 1'b1;
        tpb_pkg::ACT_CLEAR: pin_q <= 1'b0;
        tpb_pkg::ACT_TOGGLE: pin_q <= !pin_q;
        default: pin_q <= pin_q;
      endcase
    end
  end

  // Driving only in waveform mode with another event source avoids fighting the input.
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= wave && ev_src != tpb_pkg::SRC_PIN_B;
    end
  end

  assign O_PRDATA = prdata_q;
  assign O_PREADY = pready_q;
  assign O_PSLVERR = pslverr_q;
  assign O_PIN_B = pin_q;
  assign O_PIN_B_OE = oe_q;

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);

  property p_cmp_b_set;
    wave && hit_b && !hit_c && !ev_hit && !sw_trig_q && act_b == tpb_pkg::ACT_SET |=> pin_q;
  endproperty
  a_cmp_b_set: assert property (p_cmp_b_set) else $error("compare B set missed");

  property p_cmp_c_clear;
    wave && hit_c && !ev_hit && !sw_trig_q && act_c == tpb_pkg::ACT_CLEAR |=> !pin_q;
  endproperty
  a_cmp_c_clear: assert property (p_cmp_c_clear) else $error("compare C clear missed");

  property p_event_toggle;
    wave && ev_hit && !sw_trig_q && act_ev == tpb_pkg::ACT_TOGGLE |=> pin_q != $past(pin_q);
  endproperty
  a_event_toggle: assert property (p_event_toggle) else $error("event toggle missed");

  property p_sw_overrides;
    wave && sw_trig_q && act_sw == tpb_pkg::ACT_NONE |=> $stable(pin_q);
  endproperty
  a_sw_overrides: assert property (p_sw_overrides) else $error("trigger priority lost");

  property p_count_read;
    access && pready_q && I_PADDR == tpb_pkg::OFF_LIVE_COUNT && !I_PWRITE
      |-> O_PRDATA[31:16] == 16'h0000 && !O_PSLVERR;
  endproperty
  a_count_read: assert property (p_count_read) else $error("count read upper bits set");

  property p_reg_a_locked;
    wr_en && I_PADDR == tpb_pkg::OFF_CAPTURE_COMPARE_A && !wave |=> $stable(reg_a_q);
  endproperty
  a_reg_a_locked: assert property (p_reg_a_locked) else $error("A written in capture");

  property p_reg_b_write;
    wr_en && I_PADDR == tpb_pkg::OFF_CAPTURE_COMPARE_B && wave
      |=> reg_b_q == $past(I_PWDATA[15:0]);
  endproperty
  a_reg_b_write: assert property (p_reg_b_write) else $error("B write lost");

  property p_reg_c_write;
    wr_en && I_PADDR == tpb_pkg::OFF_PERIOD_COMPARE_C ##1 !wr_en
      |=> reg_c_q == $past(I_PWDATA[15:0], 2);
  endproperty
  a_reg_c_write: assert property (p_reg_c_write) else $error("C write lost");

  property p_capture_no_drive;
    !wave [*2] |-> !oe_q && $stable(pin_q);
  endproperty
  a_capture_no_drive: assert property (p_capture_no_drive) else $error("pin driven");

  property p_cmp_b_toggle;
    wave && hit_b && !hit_c && !ev_hit && !sw_trig_q && act_b == tpb_pkg::ACT_TOGGLE
      |=> pin_q != $past(pin_q);
  endproperty
  a_cmp_b_toggle: assert property (p_cmp_b_toggle) else $error("compare B toggle missed");

  property p_cmp_c_set;
    wave && hit_c && !ev_hit && !sw_trig_q && act_c == tpb_pkg::ACT_SET |=> pin_q;
  endproperty
  a_cmp_c_set: assert property (p_cmp_c_set) else $error("compare C set missed");

  property p_event_clear;
    wave && ev_hit && !sw_trig_q && act_ev == tpb_pkg::ACT_CLEAR |=> !pin_q;
  endproperty
  a_event_clear: assert property (p_event_clear) else $error("event clear missed");

  property p_sw_set;
    wave && sw_trig_q && act_sw == tpb_pkg::ACT_SET |=> pin_q;
  endproperty
  a_sw_set: assert property (p_sw_set) else $error("trigger set missed");

  property p_count_frozen;
    !enable_q |=> $stable(count_q);
  endproperty
  a_count_frozen: assert property (p_count_frozen) else $error("count moved while stopped");

  property p_reg_b_locked;
    wr_en && I_PADDR == tpb_pkg::OFF_CAPTURE_COMPARE_B && !wave |=> $stable(reg_b_q);
  endproperty
  a_reg_b_locked: assert property (p_reg_b_locked) else $error("B written in capture");

  property p_reg_c_capture;
    wr_en && I_PADDR == tpb_pkg::OFF_PERIOD_COMPARE_C && !wave
      |=> reg_c_q == $past(I_PWDATA[15:0]);
  endproperty
  a_reg_c_capture: assert property (p_reg_c_capture) else $error("C capture write lost");

  property p_oe_wave;
    wave && ev_src != tpb_pkg::SRC_PIN_B |=> oe_q;
  endproperty
  a_oe_wave: assert property (p_oe_wave) else $error("pin B not driven in waveform");

  property p_pin_b_input;
    ev_src == tpb_pkg::SRC_PIN_B |=> !O_PIN_B_OE;
  endproperty
  a_pin_b_input: assert property (p_pin_b_input) else $error("pin B driven as input");

  c_cmp_b: cover property (wave && hit_b && act_b != tpb_pkg::ACT_NONE);
  c_event: cover property (wave && ev_hit ##1 pin_q);
  c_sw_and_cmp: cover property (wave && sw_trig_q && hit_c);
  c_unmapped: cover property (O_PREADY && O_PSLVERR);
  c_event_both: cover property (wave && ev_hit && ev_edge == tpb_pkg::EDGE_BOTH);
endmodule // tpb_channel

//--- testbench/tpb_pin_model.sv
// Behavioural model of the far side of pin B and of the external event lines.
`timescale 1ns/10ps
module tpb_pin_model (
  input wire logic i_clk,
  input wire logic i_oe,
  input wire logic i_pin_o,
  input wire logic [2:0] i_ev,
  output logic o_pin_i,
  output logic [2:0] o_xc
);
  // The pin has a pull-up, so it rests high whenever the channel lets go of it.
  assign o_pin_i = i_oe ? i_pin_o : 1'b1;
  initial o_xc = 3'h0;
  always @(posedge i_clk) begin
    o_xc <= i_ev;
  end
endmodule // tpb_pin_model

//--- testbench/timer_pin_b_waveform_and_compare_regs_tb.sv
// Self-checking bench for the pin B timer channel: registers over APB and pin B actions.
`timescale 1ns/10ps
module timer_pin_b_waveform_and_compare_regs_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, pin_o, pin_oe, pin_i;
  logic [2:0] ev = 3'h0;
  logic [2:0] xc;
  logic [31:0] seed = 32'h0000_003B;
  logic [31:0] rd;
  logic err;
  int mismatches = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [7:0] offs [4] = '{tpb_pkg::OFF_CAPTURE_COMPARE_A, tpb_pkg::OFF_CAPTURE_COMPARE_B,
    tpb_pkg::OFF_PERIOD_COMPARE_C, tpb_pkg::OFF_LIVE_COUNT};

  always #20 clk = ~clk;

  tpb_channel dut (.I_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .I_XC(xc), .I_PIN_B(pin_i), .O_PIN_B(pin_o), .O_PIN_B_OE(pin_oe));
  tpb_pin_model far (.i_clk(clk), .i_oe(pin_oe), .i_pin_o(pin_o), .i_ev(ev),
    .o_pin_i(pin_i), .o_xc(xc));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic act(input logic p, input logic [1:0] c);
    case (c)
      tpb_pkg::ACT_SET: return 1'b1;
      tpb_pkg::ACT_CLEAR: return 1'b0;
      tpb_pkg::ACT_TOGGLE: return ~p;
      default: return p;
    endcase
  endfunction

  // Waveform mode with the chosen source and edge; acts holds trigger, event, C, B actions.
  function automatic logic [31:0] mode(input logic [1:0] src, input logic [1:0] edg,
    input logic [7:0] acts);
    return {acts, 8'h00, 1'b1, 3'h0, src, edg, 8'h00};
  endfunction

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s exp %h got %h", name, exp, got);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // No local limit: a transfer that never ends is caught by the cycle ceiling below.
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    idle(3);
    rst <= 1'b0;
  endtask

  // The whole run needs about eleven hundred cycles.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      mismatches++;
      final_report();
    end
  end

  initial begin
    logic [31:0] v;
    logic p;
    logic q;
    logic [1:0] src;
    logic [1:0] edg;
    do_reset();
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, offs[i], 32'h0000_0000);
      chk("reset_value", 32'h0000_0000, rd);
      v = rnd();
      apb(1'b1, offs[i], v);
      apb(1'b0, offs[i], 32'h0000_0000);
      chk("capture_write", (i == 2) ? {16'h0000, v[15:0]} : 32'h0000_0000, rd);
    end
    apb(1'b1, tpb_pkg::OFF_MODE, mode(2'h1, tpb_pkg::EDGE_RISING, 8'h00));
    for (int i = 0; i < 3; i++) begin
      v = rnd();
      apb(1'b1, offs[i], v);
      apb(1'b0, offs[i], 32'h0000_0000);
      chk("wave_write", {16'h0000, v[15:0]}, rd);
    end
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk("unmapped_err", 32'h0000_0001, 32'(err));
    apb(1'b1, tpb_pkg::OFF_CONTROL, 32'h0000_0001);
    idle(40);
    apb(1'b0, tpb_pkg::OFF_LIVE_COUNT, 32'h0000_0000);
    chk("count_upper", 32'h0000_0000, {rd[31:16], 16'h0000});
    chk("count_runs", 32'h0000_0001, 32'(rd[15:0] > 16'h000F));
    chk("oe_wave", 32'h0000_0001, 32'(pin_oe));
    apb(1'b1, tpb_pkg::OFF_MODE, mode(tpb_pkg::SRC_PIN_B, tpb_pkg::EDGE_RISING, 8'hC0));
    idle(2);
    chk("oe_pin_src", 32'h0000_0000, 32'(pin_oe));
    apb(1'b1, tpb_pkg::OFF_MODE, 32'hC000_0000);
    p = pin_o;
    apb(1'b1, tpb_pkg::OFF_CONTROL, 32'h0000_0004);
    idle(4);
    chk("capture_pin", 32'(p), 32'(pin_o));
    chk("capture_oe", 32'h0000_0000, 32'(pin_oe));
    // Source s: 0 compare B, 1 compare C, 2 event on one of the three external lines, 3 software trigger.
    for (int s = 0; s < 4; s++) begin
      for (int c = 0; c < 4; c++) begin
        do_reset();
        v = rnd();
        p = v[0];
        // Event runs pick one of the three lines and an edge; other runs keep events off.
        src = (v[2:1] == 2'h0) ? 2'h3 : v[2:1];
        edg = (s != 2) ? tpb_pkg::EDGE_NONE : (v[4:3] == 2'h0) ? tpb_pkg::EDGE_BOTH : v[4:3];
        apb(1'b1, tpb_pkg::OFF_MODE,
          mode(2'h1, tpb_pkg::EDGE_RISING, {(p ? 2'h1 : 2'h2), 6'h00}));
        apb(1'b1, tpb_pkg::OFF_CONTROL, 32'h0000_0004);
        idle(4);
        chk("pin_preset", 32'(p), 32'(pin_o));
        apb(1'b1, tpb_pkg::OFF_MODE, mode(src, edg, 8'(c) << (2 * s)));
        apb(1'b1, (s == 0) ? tpb_pkg::OFF_CAPTURE_COMPARE_B : tpb_pkg::OFF_PERIOD_COMPARE_C,
          32'h0000_0005);
        if (s < 2) apb(1'b1, tpb_pkg::OFF_CONTROL, 32'h0000_0001);
        if (s == 3) apb(1'b1, tpb_pkg::OFF_CONTROL, 32'h0000_0004);
        if (s == 2) begin
          ev <= 3'h1 << (src - 2'h1);
          idle(6);
          ev <= 3'h0;
        end
        idle(30);
        // A pulse seen on both edges applies the action twice.
        q = act(p, 2'(c));
        if (edg == tpb_pkg::EDGE_BOTH) q = act(q, 2'(c));
        chk("pin_action", 32'(q), 32'(pin_o));
        chk("pin_oe", 32'h0000_0001, 32'(pin_oe));
      end
    end
    final_report();
  end
endmodule // timer_pin_b_waveform_and_compare_regs_tb
